// *** bench/adc_setup_filter_control_test.sv ***
// Self-checking bench for the setup register and word timing.
// Assumes shortened word periods and a host that opens each access with a comm write.
module adc_setup_filter_control_test
    import adc_setup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WC [8] = '{64, 128, 192, 256, 320, 384, 448, 512};
    typedef struct {logic [7:0] v; logic [2:0] o; int p;} row_t;
    // Setup value, expected {clock range, unipolar, buffer}, word period
    row_t rows [8] = '{'{8'h02, 3'h1, 64}, '{8'h0C, 3'h2, 128}, '{8'h16, 3'h3, 192},
        '{8'h18, 3'h0, 256}, '{8'h22, 3'h5, 320}, '{8'h2C, 3'h6, 384},
        '{8'h36, 3'h7, 448}, '{8'h38, 3'h4, 512}};
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_mod_bit = 1'b1;
    logic sclk, din, cs_n, dout, rdy_n, strobe, ck, un, bf, stby;
    logic [1:0] gain;
    logic [7:0] rx, hi;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int d;
    always #4 i_clock = ~i_clock;
    adc_setup_filter_control #(.DECIM(8), .WORD_CYCLES(WC)) u_dut (.i_clock(i_clock),
        .i_rst(i_rst), .i_sclk(sclk), .i_din(din), .i_cs_n(cs_n), .i_mod_bit(i_mod_bit),
        .o_dout(dout), .o_conversion_ready_n(rdy_n), .o_word_strobe(strobe),
        .o_clock_range(ck), .o_unipolar(un), .o_buffer_enable(bf), .o_standby(stby),
        .o_gain(gain));
    serial_host u_host (.i_clock(i_clock), .i_dout(dout), .o_sclk(sclk), .o_din(din),
        .o_cs_n(cs_n));
    // ==========================================
    // Helpers
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check
    task automatic rd_reg(input logic [7:0] comm, output logic [7:0] v);
        u_host.xfer(comm, v);
        u_host.xfer(8'h00, v);
    endtask : rd_reg
    task automatic wr_setup(input logic [7:0] v);
        u_host.xfer(8'h10, rx);
        u_host.xfer(v, rx);
    endtask : wr_setup
    // Counts cycles up to the next strobe, giving up at lim
    task automatic wait_strobe(input int lim, output int n);
        n = 0;
        do begin
            @(negedge i_clock);
            n++;
        end while (strobe !== 1'b1 && n < lim);
    endtask : wait_strobe
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ==========================================
    // Sequence
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        foreach (rows[i]) begin
            wr_setup(rows[i].v);
            wait_strobe(4 * rows[i].p + 64, d);
            check("first word", 16'h0001,
                16'(d > 3 * rows[i].p - 16 && d < 3 * rows[i].p + 16));
            check("ready low", 16'h0000, 16'(rdy_n));
            wait_strobe(rows[i].p + 64, d);
            check("word period", 16'(rows[i].p), 16'(d));
            rd_reg(8'h18, rx);
            check("setup", 16'(rows[i].v), 16'(rx));
            check("pins", 16'(rows[i].o), 16'({ck, un, bf}));
        end
        // Hold stops words; release settles in three periods
        wr_setup(8'h39);
        wait_strobe(1100, d);
        check("held", 16'h044C, 16'(d));
        wr_setup(8'h38);
        wait_strobe(2100, d);
        check("sync settle", 16'h0001, 16'(d > 1520 && d < 1552));
        // Full-scale stream since reset; read fits inside one period
        u_host.xfer(8'h38, rx);
        u_host.xfer(8'h00, hi);
        u_host.xfer(8'h00, rx);
        check("data", FULL_SCALE, {hi, rx});
        check("ready after read", 16'h0001, 16'(rdy_n));
        wait_strobe(600, d);
        // Zero stream from here on; the calibration write restarts the filter
        @(posedge i_clock);
        i_mod_bit <= 1'b0;
        wr_setup(8'h78);
        check("cal busy", 16'h0001, 16'(rdy_n));
        wait_strobe(2100, d);
        check("cal done", 16'h0000, 16'(rdy_n));
        rd_reg(8'h18, rx);
        check("mode back", 16'h0038, 16'(rx));
        u_host.xfer(8'h38, rx);
        u_host.xfer(8'h00, hi);
        u_host.xfer(8'h00, rx);
        check("zero data", 16'h0000, {hi, rx});
        // Reset in mid-run
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        @(negedge i_clock);
        check("reset pins", 16'h0060, 16'({rdy_n, ck, un, bf, stby, gain}));
        rd_reg(8'h18, rx);
        check("reset setup", 16'(SETUP_RESET), 16'(rx));
        give_verdict();
    end
endmodule : adc_setup_filter_control_test

// *** bench/serial_host.sv ***
// Host side of the three-wire serial port, one byte per call.
// Assumes the device samples data on sclk rising and moves data out on falling.
module serial_host (
    input wire logic i_clock,
    input wire logic i_dout,
    output logic o_sclk,
    output logic o_din,
    output logic o_cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial begin
        o_sclk = 1'b1;
        o_din = 1'b0;
        o_cs_n = 1'b1;
    end
    // ==========================================
    // Idle data line
    // Toggles so an undriven line never looks like a held value
    always @(posedge i_clock) begin
        if (!busy) begin
            o_din <= ~o_din;
        end
    end
    // ==========================================
    // Byte transfer, MSB first, sclk 8 clocks low and 9 clocks high per bit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        busy = 1'b1;
        @(posedge i_clock);
        o_cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_clock);
            o_sclk <= 1'b0;
            o_din <= tx[i];
            repeat (8) @(posedge i_clock);
            o_sclk <= 1'b1;
            rx[i] = i_dout;
            repeat (8) @(posedge i_clock);
        end
        o_cs_n <= 1'b1;
        busy = 1'b0;
    endtask : xfer
endmodule : serial_host

// *** src/adc_setup_filter_control.sv ***
// Setup register, serial command port and sinc3 filter control of the converter.
// Assumes serial pins and modulator bit arrive asynchronously; one 125 MHz clock.
// What this block does
// - Eight-bit read/write setup register at select code 0,1, resets to 28 hex.
// - Bit order: mode pair, clock range, rate pair, polarity, buffer, filter hold.
// - Clock range bit is 1 after reset.
// - Rate select pair is 0,1 after reset.
// - Word rate chosen from clock range plus both rate select bits.
// - One new word per first-notch period.
// - Modulator stream passes a third-order sinc decimator, notch equals word rate.
// - Unsynchronised step settles within four word periods.
// - Step under filter hold settles three word periods after hold falls.
// - Filter -3 dB bandwidth is 0.262 times the notch frequency.
// - Mode 0,0 normal; 0,1 self-calibrates, ready high, then back to 0,0.
// - Filter hold resets filter; release leaves serial port and low ready intact.
// - Polarity 0 bipolar (reset default), 1 unipolar.
module adc_setup_filter_control
    import adc_setup_pkg::*;
#(
    parameter int DECIM = 64,
    parameter int unsigned WORD_CYCLES [8] = WORD_CYCLES_DEF
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_cs_n,
    input wire logic i_mod_bit,
    output logic o_dout,
    output logic o_conversion_ready_n,
    output logic o_word_strobe,
    output logic o_clock_range,
    output logic o_unipolar,
    output logic o_buffer_enable,
    output logic o_standby,
    output logic [1:0] o_gain
);
    localparam int ACC_W = 1 + 3 * $clog2(DECIM);

    logic [3:0] pins_s;
    logic sclk_s;
    logic din_s;
    logic cs_n_s;
    logic mod_s;
    logic sclk_q_reg;
    logic sclk_rise;
    logic sclk_fall;
    port_state_t state_reg;
    logic [4:0] bit_cnt_reg;
    logic [5:0] ones_reg;
    logic [6:0] shift_reg;
    logic [15:0] out_shift_reg;
    logic [1:0] rs_reg;
    logic rw_reg;
    logic setup_wr_reg;
    logic [7:0] setup_wdata_reg;
    logic read_done_reg;
    logic [7:0] setup_reg;
    logic [7:0] comm_word;
    logic [15:0] data_reg;
    logic mod_tick;
    logic word_tick;
    logic filter_hold;
    logic cal_start;
    logic cal_busy_reg;
    logic publish;
    logic [1:0] settle_reg;
    logic [ACC_W-1:0] int1_reg, int2_reg, int3_reg;
    logic [ACC_W-1:0] dly1_reg, dly2_reg, dly3_reg;
    logic [ACC_W-1:0] comb1, comb2, comb3;
    logic [15:0] bip_code, out_code;
    logic [ACC_W-1:0] int3_next;
    logic [ACC_W+15:0] code_wide;

    // ==========================================================
    // Pin synchronisers
    pin_sync #(.W(4), .INIT(PIN_INIT)) u_pins (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pins({i_mod_bit, i_cs_n, i_din, i_sclk}),
        .o_pins(pins_s)
    );
    assign {mod_s, cs_n_s, din_s, sclk_s} = pins_s;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sclk_q_reg <= 1'b1;
        end else begin
            sclk_q_reg <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_q_reg & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_q_reg & ~cs_n_s;

    function automatic logic [15:0] read_word(input logic [1:0] rs);
        logic [7:0] comm;
        comm = {o_conversion_ready_n, 1'b0, rs, 1'b1, o_standby, o_gain};
        if (rs == RS_COMM) begin
            read_word = {comm, REG_ZERO};
        end else if (rs == RS_SETUP) begin
            read_word = {setup_reg, REG_ZERO};
        end else if (rs == RS_DATA) begin
            read_word = data_reg;
        end else begin
            read_word = {REG_ZERO, REG_ZERO};
        end
    endfunction : read_word

    // ==========================================================
    // Serial command port
    assign comm_word = {1'b0, shift_reg[5:0], din_s};

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_COMM_WAIT;
            bit_cnt_reg <= '0;
            ones_reg <= '0;
            shift_reg <= '0;
            out_shift_reg <= '0;
            o_dout <= 1'b1;
            rs_reg <= RS_COMM;
            rw_reg <= 1'b0;
            o_standby <= 1'b0;
            o_gain <= GAIN_RESET;
            setup_wr_reg <= 1'b0;
            setup_wdata_reg <= SETUP_RESET;
            read_done_reg <= 1'b0;
        end else begin
            setup_wr_reg <= 1'b0;
            read_done_reg <= 1'b0;
            if (sclk_fall && state_reg == ST_READ) begin
                // Bit leaves before the shift, so the first fall shows the MSB
                out_shift_reg <= {out_shift_reg[14:0], 1'b0};
                o_dout <= out_shift_reg[15];
            end
            if (sclk_rise) begin
                ones_reg <= din_s ? ones_reg + 1'b1 : '0;
                shift_reg <= {shift_reg[5:0], din_s};
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                if (din_s && ones_reg == RESYNC_ONES - 1'b1) begin
                    // Long run of ones puts a lost host back in step
                    state_reg <= ST_COMM_WAIT;
                    ones_reg <= '0;
                end else begin
                    case (state_reg)
                        ST_COMM_WAIT: begin
                            bit_cnt_reg <= '0;
                            if (!din_s) begin
                                state_reg <= ST_COMM_BITS;
                            end
                        end
                        ST_COMM_BITS: begin
                            if (bit_cnt_reg == 5'h06) begin
                                rs_reg <= comm_word[COMM_RS_HI:COMM_RS_LO];
                                rw_reg <= comm_word[COMM_RW];
                                o_standby <= comm_word[COMM_STBY];
                                o_gain <= comm_word[COMM_GAIN_HI:COMM_GAIN_LO];
                                bit_cnt_reg <= '0;
                                if (comm_word[COMM_RW]) begin
                                    state_reg <= ST_READ;
                                    out_shift_reg <= read_word(comm_word[COMM_RS_HI:COMM_RS_LO]);
                                end else if (comm_word[COMM_RS_HI:COMM_RS_LO] == RS_COMM) begin
                                    state_reg <= ST_COMM_WAIT;
                                end else begin
                                    state_reg <= ST_WRITE;
                                end
                            end
                        end
                        ST_WRITE: begin
                            if (bit_cnt_reg == reg_length(rs_reg) - 1'b1) begin
                                state_reg <= ST_COMM_WAIT;
                                // Test and data writes are accepted and dropped
                                setup_wr_reg <= (rs_reg == RS_SETUP);
                                setup_wdata_reg <= {shift_reg, din_s};
                            end
                        end
                        ST_READ: begin
                            if (bit_cnt_reg == reg_length(rs_reg) - 1'b1) begin
                                state_reg <= ST_COMM_WAIT;
                                read_done_reg <= 1'b1;
                            end
                        end
                        default: begin
                            state_reg <= ST_COMM_WAIT;
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Setup register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            setup_reg <= SETUP_RESET;
        end else if (setup_wr_reg) begin
            setup_reg <= setup_wdata_reg;
        end else if (cal_busy_reg && publish) begin
            setup_reg[BIT_MODE_HI:BIT_MODE_LO] <= MODE_NORMAL;
        end
    end
    assign o_clock_range = setup_reg[BIT_CLK_RANGE];
    assign o_unipolar = setup_reg[BIT_POLARITY];
    assign o_buffer_enable = setup_reg[BIT_BUFFER];

    // ==========================================================
    // Word timing and filter control
    // Any setup write restarts the filter so a new rate never mixes with the old one
    assign filter_hold = setup_reg[BIT_FILTER_HOLD] | setup_wr_reg | o_standby;
    assign cal_start = setup_wr_reg &&
        setup_wdata_reg[BIT_MODE_HI:BIT_MODE_LO] == MODE_SELF_CAL;
    assign publish = word_tick && !filter_hold && settle_reg >= SETTLE_WORDS - 1'b1;

    word_timer #(.DECIM(DECIM), .WORD_CYCLES(WORD_CYCLES)) u_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_hold(filter_hold),
        .i_rate({setup_reg[BIT_CLK_RANGE], setup_reg[BIT_RATE_HI], setup_reg[BIT_RATE_LO]}),
        .o_mod_tick(mod_tick),
        .o_word_tick(word_tick)
    );

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            settle_reg <= '0;
        end else if (filter_hold) begin
            settle_reg <= '0;
        end else if (word_tick && settle_reg != SETTLE_WORDS) begin
            settle_reg <= settle_reg + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cal_busy_reg <= 1'b0;
        end else if (cal_start) begin
            cal_busy_reg <= 1'b1;
        end else if (publish) begin
            cal_busy_reg <= 1'b0;
        end
    end

    // Hold never touches ready; a new word wins over a coincident data read
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_conversion_ready_n <= 1'b1;
            o_word_strobe <= 1'b0;
            data_reg <= MID_SCALE;
        end else begin
            o_word_strobe <= publish;
            if (publish) begin
                o_conversion_ready_n <= 1'b0;
                data_reg <= out_code;
            end else if (cal_start) begin
                o_conversion_ready_n <= 1'b1;
            end else if (read_done_reg && rs_reg == RS_DATA) begin
                o_conversion_ready_n <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Sinc3 decimator: fixed decimation keeps gain constant at every rate
    // Notch at the word rate gives a -3 dB point of 0.262 of it by construction
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            {int1_reg, int2_reg, int3_reg} <= '0;
            {dly1_reg, dly2_reg, dly3_reg} <= '0;
        end else if (filter_hold) begin
            {int1_reg, int2_reg, int3_reg} <= '0;
            {dly1_reg, dly2_reg, dly3_reg} <= '0;
        end else begin
            if (mod_tick) begin
                int1_reg <= int1_reg + ACC_W'(mod_s);
                int2_reg <= int2_reg + int1_reg;
                int3_reg <= int3_next;
            end
            if (word_tick) begin
                dly1_reg <= int3_next;
                dly2_reg <= comb1;
                dly3_reg <= comb2;
            end
        end
    end
    // Word tick always lands on a sample tick, so the comb takes this sample too
    assign int3_next = int3_reg + int2_reg;
    assign comb1 = int3_next - dly1_reg;
    assign comb2 = comb1 - dly2_reg;
    assign comb3 = comb2 - dly3_reg;
    // Zero padding keeps the slice in range for small decimations
    assign code_wide = {comb3, 16'h0000};
    assign bip_code = comb3[ACC_W-1] ? FULL_SCALE : code_wide[ACC_W+14 -: 16];
    assign out_code = !setup_reg[BIT_POLARITY] ? bip_code :
        (bip_code >= MID_SCALE ? {bip_code[14:0], 1'b0} : '0);

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sequence cal_begin;
        cal_start;
    endsequence
    sequence cal_end;
        cal_busy_reg && publish;
    endsequence

    a_setup_reset_value: assert property ($past(i_rst) |-> setup_reg == SETUP_RESET)
        else $error("setup register not at reset value after reset");
    a_strobe_one_cycle: assert property (o_word_strobe |=> !o_word_strobe)
        else $error("word strobe longer than one cycle");
    a_strobe_with_ready: assert property (o_word_strobe |-> !o_conversion_ready_n)
        else $error("word strobe without ready low");
    a_hold_no_word: assert property (setup_reg[BIT_FILTER_HOLD] [*2] |-> !o_word_strobe)
        else $error("word delivered while filter held");
    a_hold_keeps_ready: assert property (
        (!o_conversion_ready_n && setup_reg[BIT_FILTER_HOLD] && !read_done_reg)
        |=> !o_conversion_ready_n)
        else $error("filter hold disturbed a low ready");
    a_cal_ready_high: assert property (cal_begin |=> o_conversion_ready_n && cal_busy_reg)
        else $error("calibration start did not raise ready");
    a_cal_mode_clear: assert property (
        cal_end |=> setup_reg[BIT_MODE_HI:BIT_MODE_LO] == MODE_NORMAL && !o_conversion_ready_n)
        else $error("calibration end did not restore normal mode");
    a_settle_words: assert property (o_word_strobe |-> settle_reg == SETTLE_WORDS)
        else $error("word published before filter settled");

endmodule : adc_setup_filter_control

// *** src/adc_setup_pkg.sv ***
// Constants, field layout and state codes shared by the converter setup logic.
// Assumes a single 125 MHz system clock and one asynchronous active-high reset.
package adc_setup_pkg;

    // ==========================================================
    // Register select codes and reset values
    localparam logic [1:0] RS_COMM = 2'h0;
    localparam logic [1:0] RS_SETUP = 2'h1;
    localparam logic [1:0] RS_TEST = 2'h2;
    localparam logic [1:0] RS_DATA = 2'h3;
    localparam logic [7:0] SETUP_RESET = 8'h28;
    localparam logic [7:0] REG_ZERO = 8'h00;

    // ==========================================================
    // Setup register fields
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_CLK_RANGE = 5;
    localparam int BIT_RATE_HI = 4;
    localparam int BIT_RATE_LO = 3;
    localparam int BIT_POLARITY = 2;
    localparam int BIT_BUFFER = 1;
    localparam int BIT_FILTER_HOLD = 0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SELF_CAL = 2'h1;

    // ==========================================================
    // Communications register fields
    localparam int COMM_READY = 7;
    localparam int COMM_RS_HI = 5;
    localparam int COMM_RS_LO = 4;
    localparam int COMM_RW = 3;
    localparam int COMM_STBY = 2;
    localparam int COMM_GAIN_HI = 1;
    localparam int COMM_GAIN_LO = 0;
    localparam logic [1:0] GAIN_RESET = 2'h0;

    // ==========================================================
    // Serial port and filter figures
    localparam logic [4:0] REG_BITS = 5'h08;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [5:0] RESYNC_ONES = 6'h20;
    localparam logic [1:0] SETTLE_WORDS = 2'h3;
    localparam int SETTLE_UNSYNC_WORDS = 4;
    localparam int BW_RATIO_PERMILLE = 262;
    localparam logic [15:0] MID_SCALE = 16'h8000;
    localparam logic [15:0] FULL_SCALE = 16'hFFFF;
    localparam logic [3:0] PIN_INIT = 4'h5;

    // ==========================================================
    // Word rates: index is {clock range, rate select hi, rate select lo}
    localparam int unsigned CLOCK_HZ = 125_000_000;
    localparam int unsigned NOTCH_HZ [8] = '{20, 40, 100, 200, 50, 100, 250, 500};
    localparam int unsigned WORD_CYCLES_DEF [8] = '{
        CLOCK_HZ / NOTCH_HZ[0], CLOCK_HZ / NOTCH_HZ[1], CLOCK_HZ / NOTCH_HZ[2],
        CLOCK_HZ / NOTCH_HZ[3], CLOCK_HZ / NOTCH_HZ[4], CLOCK_HZ / NOTCH_HZ[5],
        CLOCK_HZ / NOTCH_HZ[6], CLOCK_HZ / NOTCH_HZ[7]};

    typedef enum logic [3:0] {
        ST_COMM_WAIT = 4'h1,
        ST_COMM_BITS = 4'h2,
        ST_WRITE = 4'h4,
        ST_READ = 4'h8
    } port_state_t;

    function automatic logic [4:0] reg_length(input logic [1:0] rs);
        reg_length = (rs == RS_DATA) ? DATA_BITS : REG_BITS;
    endfunction : reg_length

endpackage : adc_setup_pkg

// *** src/pin_sync.sv ***
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to i_clock; output moves when stages two and three agree.
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [W-1:0] i_pins,
    output logic [W-1:0] o_pins
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage3_reg;

    // ==========================================================
    // Per-bit lanes
    for (genvar g = 0; g < W; g++) begin : g_lane
        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                stage1_reg[g] <= INIT[g];
                stage2_reg[g] <= INIT[g];
                stage3_reg[g] <= INIT[g];
                o_pins[g] <= INIT[g];
            end else begin
                stage1_reg[g] <= i_pins[g];
                stage2_reg[g] <= stage1_reg[g];
                stage3_reg[g] <= stage2_reg[g];
                if (stage2_reg[g] == stage3_reg[g]) begin
                    o_pins[g] <= stage3_reg[g];
                end
            end
        end
    end

endmodule : pin_sync

// *** src/word_timer.sv ***
// Master-clock divider giving the modulator sample tick and the output word tick.
// Assumes i_hold is synchronous; word period is (WORD_CYCLES[rate]/DECIM)*DECIM cycles.
module word_timer
    import adc_setup_pkg::*;
#(
    parameter int DECIM = 64,
    parameter int unsigned WORD_CYCLES [8] = WORD_CYCLES_DEF
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_hold,
    input wire logic [2:0] i_rate,
    output logic o_mod_tick,
    output logic o_word_tick
);
    localparam int DW = $clog2(DECIM);
    logic [31:0] div_reg;
    logic [DW-1:0] dec_reg;
    logic [31:0] div_term;
    logic [31:0] gap_reg;
    logic gap_seen_reg;

    // Short tables still tick every cycle rather than never
    assign div_term = (WORD_CYCLES[i_rate] / DECIM > 1) ? 32'(WORD_CYCLES[i_rate] / DECIM - 1) : '0;

    // ==========================================================
    // Divider chain
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_reg <= '0;
            dec_reg <= '0;
            o_mod_tick <= 1'b0;
            o_word_tick <= 1'b0;
        end else if (i_hold) begin
            div_reg <= '0;
            dec_reg <= '0;
            o_mod_tick <= 1'b0;
            o_word_tick <= 1'b0;
        end else begin
            o_mod_tick <= 1'b0;
            o_word_tick <= 1'b0;
            if (div_reg == div_term) begin
                div_reg <= '0;
                o_mod_tick <= 1'b1;
                if (dec_reg == DW'(DECIM - 1)) begin
                    dec_reg <= '0;
                    o_word_tick <= 1'b1;
                end else begin
                    dec_reg <= dec_reg + 1'b1;
                end
            end else begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b0;
        end else if (i_hold) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b0;
        end else if (o_word_tick) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 1'b1;
        end
    end

    a_word_period: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_word_tick && gap_seen_reg && !$past(i_hold)) |-> (gap_reg == (div_term + 1) * DECIM - 1))
        else $error("word tick spacing does not match the selected rate");

endmodule : word_timer
